// >>> include/rstsup_pkg.sv
// Package: register map, field positions, reset values and timing for the reset supervisor
package rstsup_pkg;
    // Register byte offsets (APB, one aligned word each)
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_SWRST = 8'h04;
    localparam logic [7:0] OFF_LVCFG = 8'h08;
    localparam logic [7:0] OFF_WDCTRL = 8'h0C;
    localparam logic [7:0] OFF_WDKICK = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_BUZZ = 8'h18;
    localparam logic [7:0] OFF_MODE = 8'h1C;

    // CTRL fields
    localparam int CTRL_SWRST_DIS = 0;
    localparam int CTRL_AREG_EN = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0002;

    // LVCFG fields: trip codes, reset-vs-irq choice and monitor enables
    localparam int LV_DTRIP_LSB = 0;
    localparam int LV_ATRIP_LSB = 4;
    localparam int LV_DLV_RST = 8;
    localparam int LV_ALV_RST = 9;
    localparam int LV_DLV_EN = 10;
    localparam int LV_ALV_EN = 11;
    localparam int LV_AHV_EN = 12;

    // STATUS bits
    localparam int ST_PREC = 0;
    localparam int ST_EXT = 1;
    localparam int ST_SW = 2;
    localparam int ST_WD = 3;
    localparam int ST_DLV_IRQ = 4;
    localparam int ST_ALV_IRQ = 5;
    localparam int ST_AHV_IRQ = 6;
    localparam int ST_LVRST = 7;

    // Power modes
    localparam logic [1:0] MODE_ACTIVE = 2'h0;
    localparam logic [1:0] MODE_SLEEP = 2'h1;
    localparam logic [1:0] MODE_HIBERNATE = 2'h2;

    // Timing
    localparam int CLK_HZ = 40_000_000;
    localparam int POR_MIN_NS = 150;
    localparam int POR_MIN_CYC = (POR_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int PREC_HOLD_US = 10;
    localparam int PREC_HOLD_CYC = PREC_HOLD_US * (CLK_HZ / 1_000_000);
    localparam int RST_STRETCH_CYC = POR_MIN_CYC;
    localparam logic [15:0] BUZZ_RESET = 16'h0100;
    localparam logic [7:0] BUZZ_ON_CYC = 8'h10;
    localparam logic [31:0] WD_TIMEOUT_RESET = 32'h0000_FFFF;
    localparam logic [3:0] TRIP_RESET = 4'h0;

    typedef enum logic [2:0] {
        RSTSUP_WAKE_IDLE = 3'b001,
        RSTSUP_WAKE_SEQ = 3'b010,
        RSTSUP_WAKE_DONE = 3'b100
    } rstsup_wake_t;
endpackage

// >>> src/rstsup_top.sv
// System reset supervisor: gathers supply, pin, software and watchdog resets
//
// Functional notes
// R01: Out-of-range supply causes system reset
// R02: System reset reaches core, peripherals, registers
// R03: Status records causes, cleared only by power-on
// R04: Power-on pulse minimum width, extended while low
// R05: After boot, precise monitor supervises supplies
// R06: Precise monitor trip equals power-on reset
// R07: Digital precise part cannot be disabled
// R08: Precise monitor off in sleep, buzzed periodically
// R09: Precise reset held off ten microseconds after release
// R10: Low-voltage trip codes, fixed high trip level
// R11: Low-voltage monitors may reset instead of interrupt
// R12: Low/high monitors disabled until power-on done
// R13: Buzz interrupt waits for wakeup sequence first
// R14: Firmware sets buzz period below excursion length
// R15: External reset low holds device in reset
// R16: External reset works in sleep and hibernate
// R17: External party spaces external reset assertions
// R18: Software reset bit acts as power-on reset
// R19: Control bit blocks software reset
// R20: Watchdog resets when not kicked in time
// R21: Power-on disables watchdog; enable bit sticky
// R22: Reset events also wake system to active
// R23: System reset asserts async, releases synchronously
`timescale 1ns/1ps
`default_nettype none
module rstsup_top #(
    parameter int WD_W = 32, // Watchdog counter width
    parameter int PREC_HOLD = rstsup_pkg::PREC_HOLD_CYC // Precise reset hold-off cycles
) (
    input wire logic pclk, // System clock, 40 MHz
    input wire logic presetn, // Power-on reset, async, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic digital_supply_low, // Digital supply below trip, comparator
    input wire logic analog_supply_low, // Analog supply below trip, comparator
    input wire logic analog_supply_high, // Analog supply above fixed trip
    input wire logic digital_core_regulator_low, // Digital regulator output low
    input wire logic analog_core_regulator_low, // Analog regulator output low
    input wire logic supply_ramping, // Any supply still below power-on trip
    input wire logic external_reset_n, // External reset pin, active low
    output logic system_reset_n, // Combined system reset, active low
    output logic [3:0] digital_trip_code, // Digital low trip: 1.70 V + code*250 mV
    output logic [3:0] analog_trip_code, // Analog low trip: 1.70 V + code*250 mV
    output logic monitor_enable, // Low/high monitors powered
    output logic precise_monitor_enable, // Precise monitor powered
    output logic analog_regulator_enable, // Analog regulator on
    output logic lv_irq, // Supply monitor interrupt to core
    output logic wakeup // Wakeup request to power manager
);
    // Pin and comparator synchronisers
    logic [1:0] ext_s, dlo_s, alo_s, ahi_s, vcd_s, vca_s, ramp_s;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_s <= 2'b11;
            dlo_s <= 2'b00;
            alo_s <= 2'b00;
            ahi_s <= 2'b00;
            vcd_s <= 2'b00;
            vca_s <= 2'b00;
            ramp_s <= 2'b11;
        end else begin
            ext_s <= {ext_s[0], external_reset_n};
            dlo_s <= {dlo_s[0], digital_supply_low};
            alo_s <= {alo_s[0], analog_supply_low};
            ahi_s <= {ahi_s[0], analog_supply_high};
            vcd_s <= {vcd_s[0], digital_core_regulator_low};
            vca_s <= {vca_s[0], analog_core_regulator_low};
            ramp_s <= {ramp_s[0], supply_ramping};
        end
    end

    // Power-on pulse: minimum width, extended while supplies ramp
    logic [7:0] por_cnt;
    logic por_done;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_cnt <= 8'h00;
            por_done <= 1'b0;
        end else if (ramp_s[1]) begin
            por_cnt <= 8'h00; // R04
        end else if (por_cnt < 8'(rstsup_pkg::POR_MIN_CYC)) begin
            por_cnt <= por_cnt + 8'h01; // R04
        end else begin
            por_done <= 1'b1; // R05 R12
        end
    end

    // Registers, reset by power-on and, except status and watchdog enable, by any system reset request
    logic swrst_dis, areg_en, dlv_rst, alv_rst, dlv_en, alv_en, ahv_en;
    logic [3:0] dtrip, atrip;
    logic wd_en;
    logic [WD_W-1:0] wd_timeout, wd_cnt;
    logic [15:0] buzz_period;
    logic [1:0] mode;
    logic [7:0] status;
    logic sw_req, wd_kick, sys_rst_req;
    logic wr, rd_ok;
    assign wr = psel && penable && pwrite;
    assign pready = 1'b1;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a <= rstsup_pkg::OFF_MODE) && (a[1:0] == 2'b00);
    endfunction
    assign rd_ok = mapped(paddr);
    assign pslverr = psel && penable && !rd_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            swrst_dis <= rstsup_pkg::CTRL_RESET[rstsup_pkg::CTRL_SWRST_DIS];
            areg_en <= rstsup_pkg::CTRL_RESET[rstsup_pkg::CTRL_AREG_EN];
            dtrip <= rstsup_pkg::TRIP_RESET;
            atrip <= rstsup_pkg::TRIP_RESET;
            dlv_rst <= 1'b0;
            alv_rst <= 1'b0;
            dlv_en <= 1'b0;
            alv_en <= 1'b0;
            ahv_en <= 1'b0;
            wd_timeout <= WD_W'(rstsup_pkg::WD_TIMEOUT_RESET);
            buzz_period <= rstsup_pkg::BUZZ_RESET;
            mode <= rstsup_pkg::MODE_ACTIVE;
        end else if (sys_rst_req) begin
            // Status and the watchdog enable are kept; only power-on clears them
            swrst_dis <= rstsup_pkg::CTRL_RESET[rstsup_pkg::CTRL_SWRST_DIS]; // R02
            areg_en <= rstsup_pkg::CTRL_RESET[rstsup_pkg::CTRL_AREG_EN]; // R02
            dtrip <= rstsup_pkg::TRIP_RESET; // R02
            atrip <= rstsup_pkg::TRIP_RESET;
            dlv_rst <= 1'b0;
            alv_rst <= 1'b0;
            dlv_en <= 1'b0;
            alv_en <= 1'b0;
            ahv_en <= 1'b0;
            wd_timeout <= WD_W'(rstsup_pkg::WD_TIMEOUT_RESET);
            buzz_period <= rstsup_pkg::BUZZ_RESET;
            mode <= rstsup_pkg::MODE_ACTIVE; // R22
        end else begin
            if (wr && paddr == rstsup_pkg::OFF_CTRL) begin
                swrst_dis <= pwdata[rstsup_pkg::CTRL_SWRST_DIS]; // R19
                areg_en <= pwdata[rstsup_pkg::CTRL_AREG_EN]; // R07
            end
            if (wr && paddr == rstsup_pkg::OFF_LVCFG) begin
                dtrip <= pwdata[rstsup_pkg::LV_DTRIP_LSB +: 4]; // R10
                atrip <= pwdata[rstsup_pkg::LV_ATRIP_LSB +: 4]; // R10
                dlv_rst <= pwdata[rstsup_pkg::LV_DLV_RST]; // R11
                alv_rst <= pwdata[rstsup_pkg::LV_ALV_RST]; // R11
                dlv_en <= pwdata[rstsup_pkg::LV_DLV_EN];
                alv_en <= pwdata[rstsup_pkg::LV_ALV_EN];
                ahv_en <= pwdata[rstsup_pkg::LV_AHV_EN];
            end
            if (wr && paddr == rstsup_pkg::OFF_WDCTRL) begin
                wd_timeout <= pwdata[WD_W-1:1] == '0 ? WD_W'(1) : {pwdata[WD_W-1:1], 1'b0};
            end
            if (wr && paddr == rstsup_pkg::OFF_BUZZ) begin
                buzz_period <= pwdata[15:0];
            end
            if (wr && paddr == rstsup_pkg::OFF_MODE) begin
                mode <= pwdata[1:0];
            end
        end
    end

    // Watchdog enable is sticky until power-on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_en <= 1'b0; // R21
        end else if (wr && paddr == rstsup_pkg::OFF_WDCTRL && pwdata[0]) begin
            wd_en <= 1'b1; // R21
        end
    end

    assign sw_req = wr && paddr == rstsup_pkg::OFF_SWRST && pwdata[0] && !swrst_dis; // R18 R19
    assign wd_kick = wr && paddr == rstsup_pkg::OFF_WDKICK;

    // Watchdog counter; runs only when enabled
    logic wd_fire;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_cnt <= '0;
        end else if (!wd_en || wd_kick || sys_rst_req) begin
            wd_cnt <= '0;
        end else begin
            wd_cnt <= wd_cnt + WD_W'(1); // R20
        end
    end
    assign wd_fire = wd_en && wd_cnt >= wd_timeout; // R20

    // Buzz timer: in sleep, monitors powered briefly each period
    logic [15:0] buzz_cnt;
    logic buzz_on, in_sleep, in_active;
    assign in_sleep = mode == rstsup_pkg::MODE_SLEEP;
    assign in_active = mode == rstsup_pkg::MODE_ACTIVE;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buzz_cnt <= 16'h0000;
        end else if (!in_sleep || buzz_cnt >= buzz_period) begin
            buzz_cnt <= 16'h0000;
        end else begin
            buzz_cnt <= buzz_cnt + 16'h0001; // R08
        end
    end
    assign buzz_on = in_sleep && buzz_cnt < 16'(rstsup_pkg::BUZZ_ON_CYC); // R08

    // Monitors live only after power-on; in sleep only while buzzing
    logic mon_live, prec_live;
    assign mon_live = por_done && (in_active || buzz_on); // R12 R08
    assign prec_live = por_done && (in_active || buzz_on); // R05 R07 R08

    // Precise monitor: held while the regulator stays low; the hold-off
    // counts from release, not from the trip, so a long dip cannot shorten it
    logic prec_trip, prec_arm, prec_on;
    logic [$clog2(PREC_HOLD+1)-1:0] prec_hold;
    logic prec_raw;
    assign prec_raw = prec_live && (vcd_s[1] || (areg_en && vca_s[1])); // R06 R07
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prec_on <= 1'b0;
            prec_hold <= '0;
        end else begin
            prec_on <= prec_trip; // R06
            if (prec_on && !prec_trip) begin
                prec_hold <= ($clog2(PREC_HOLD+1))'(PREC_HOLD); // R09
            end else if (prec_hold != '0) begin
                prec_hold <= prec_hold - 1'b1; // R09
            end
        end
    end
    assign prec_arm = prec_hold == '0;
    assign prec_trip = prec_raw && (prec_on || prec_arm); // R09 R01

    // Low/high voltage events
    logic dlv_ev, alv_ev, ahv_ev, lv_rst_req;
    assign dlv_ev = mon_live && dlv_en && dlo_s[1];
    assign alv_ev = mon_live && alv_en && alo_s[1];
    assign ahv_ev = mon_live && ahv_en && ahi_s[1];
    assign lv_rst_req = (dlv_ev && dlv_rst) || (alv_ev && alv_rst); // R11 R01

    // Any reset source
    assign sys_rst_req = prec_trip || !ext_s[1] || sw_req || wd_fire || lv_rst_req; // R15 R16

    // Stretch and release synchronously
    logic [7:0] stretch;
    logic rst_q1, rst_q2;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stretch <= 8'(rstsup_pkg::RST_STRETCH_CYC);
        end else if (sys_rst_req || !por_done) begin
            stretch <= 8'(rstsup_pkg::RST_STRETCH_CYC); // R06 R18
        end else if (stretch != 8'h00) begin
            stretch <= stretch - 8'h01;
        end
    end
    // Release passes two flops so all logic leaves reset on one edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_q1 <= 1'b0; // R23
            rst_q2 <= 1'b0;
        end else if (sys_rst_req) begin
            rst_q1 <= 1'b0;
            rst_q2 <= 1'b0;
        end else begin
            rst_q1 <= stretch == 8'h00; // R23
            rst_q2 <= rst_q1;
        end
    end
    assign system_reset_n = rst_q2 && !sys_rst_req; // R02 R23

    // Wakeup sequence before a buzz interrupt is seen
    rstsup_pkg::rstsup_wake_t wst, next_wst;
    logic irq_pend;
    logic [2:0] wake_cnt;
    always_comb begin
        next_wst = wst;
        case (wst)
            rstsup_pkg::RSTSUP_WAKE_IDLE: begin
                if (irq_pend && in_active) begin
                    next_wst = rstsup_pkg::RSTSUP_WAKE_DONE;
                end else if (irq_pend) begin
                    next_wst = rstsup_pkg::RSTSUP_WAKE_SEQ; // R13
                end
            end
            rstsup_pkg::RSTSUP_WAKE_SEQ: begin
                if (wake_cnt == 3'h7) begin
                    next_wst = rstsup_pkg::RSTSUP_WAKE_DONE; // R13
                end
            end
            rstsup_pkg::RSTSUP_WAKE_DONE: begin
                if (!irq_pend) begin
                    next_wst = rstsup_pkg::RSTSUP_WAKE_IDLE;
                end
            end
            default: next_wst = rstsup_pkg::RSTSUP_WAKE_IDLE;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wst <= rstsup_pkg::RSTSUP_WAKE_IDLE;
            wake_cnt <= 3'h0;
        end else begin
            wst <= next_wst;
            wake_cnt <= (wst == rstsup_pkg::RSTSUP_WAKE_SEQ) ? wake_cnt + 3'h1 : 3'h0;
        end
    end
    assign irq_pend = |status[rstsup_pkg::ST_AHV_IRQ:rstsup_pkg::ST_DLV_IRQ];
    assign lv_irq = wst == rstsup_pkg::RSTSUP_WAKE_DONE; // R13

    // Status: sticky, set wins, cleared only by power-on
    logic [7:0] st_set;
    always_comb begin
        st_set = 8'h00;
        st_set[rstsup_pkg::ST_PREC] = prec_trip;
        st_set[rstsup_pkg::ST_EXT] = !ext_s[1];
        st_set[rstsup_pkg::ST_SW] = sw_req;
        st_set[rstsup_pkg::ST_WD] = wd_fire;
        st_set[rstsup_pkg::ST_DLV_IRQ] = dlv_ev && !dlv_rst;
        st_set[rstsup_pkg::ST_ALV_IRQ] = alv_ev && !alv_rst;
        st_set[rstsup_pkg::ST_AHV_IRQ] = ahv_ev;
        st_set[rstsup_pkg::ST_LVRST] = lv_rst_req;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= 8'h00; // R03
        end else begin
            status <= status | st_set; // R03
        end
    end

    // Read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                rstsup_pkg::OFF_CTRL: prdata <= {30'h0, areg_en, swrst_dis};
                rstsup_pkg::OFF_LVCFG: prdata <= {19'h0, ahv_en, alv_en, dlv_en, alv_rst,
                    dlv_rst, atrip, dtrip};
                // Bit 0 shows the enable, never the timeout's low bit
                rstsup_pkg::OFF_WDCTRL: prdata <= 32'({wd_timeout[WD_W-1:1], wd_en}); // R21
                rstsup_pkg::OFF_STATUS: prdata <= {24'h0, status};
                rstsup_pkg::OFF_BUZZ: prdata <= {16'h0, buzz_period};
                rstsup_pkg::OFF_MODE: prdata <= {30'h0, mode};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    assign digital_trip_code = dtrip; // R10
    assign analog_trip_code = atrip; // R10
    assign monitor_enable = mon_live; // R12
    assign precise_monitor_enable = prec_live; // R08
    assign analog_regulator_enable = areg_en; // R07
    assign wakeup = sys_rst_req || wst == rstsup_pkg::RSTSUP_WAKE_SEQ; // R22
endmodule
`default_nettype wire

// >>> verification/rstsup_top_monitor.sv
// Checker: port-level properties of the reset supervisor
`timescale 1ns/1ps
`default_nettype none
module rstsup_top_monitor #(
    parameter int PREC_HOLD = 400 // Precise reset hold-off cycles
) (
    input wire logic pclk, // Clock
    input wire logic presetn, // Power-on reset
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB address
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic supply_ramping, // Supply ramp
    input wire logic external_reset_n, // Reset pin
    input wire logic system_reset_n, // System reset
    input wire logic [3:0] digital_trip_code, // Trip code
    input wire logic monitor_enable // Monitors on
);
    logic [3:0] since_por;
    logic lv_wr;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_por <= 4'h0;
        end else if (since_por != 4'hF) begin
            since_por <= since_por + 4'h1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lv_wr <= 1'b0;
        end else begin
            lv_wr <= psel && penable && pwrite && paddr == rstsup_pkg::OFF_LVCFG;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ext_hold; !external_reset_n [*3] |-> !system_reset_n; endproperty
    a_ext_hold: assert property (p_ext_hold) else $error("pin low but no reset");
    property p_ramp_hold; supply_ramping [*3] |-> !system_reset_n; endproperty
    a_ramp_hold: assert property (p_ramp_hold) else $error("ramp but no reset");
    property p_rel_sync;
        $rose(system_reset_n) |-> $past(external_reset_n, 6) && !$past(supply_ramping, 6);
    endproperty
    a_rel_sync: assert property (p_rel_sync) else $error("early release");
    property p_stretch; $fell(system_reset_n) |-> !system_reset_n [*8]; endproperty
    a_stretch: assert property (p_stretch) else $error("reset too short");
    property p_mon_off; since_por < 4'h6 |-> !monitor_enable; endproperty
    a_mon_off: assert property (p_mon_off) else $error("monitors on early");
    property p_trip_wr; $changed(digital_trip_code) |-> lv_wr || !system_reset_n; endproperty
    a_trip_wr: assert property (p_trip_wr) else $error("trip code moved");
    property p_ready; psel && penable |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready");
    property p_slverr;
        psel && penable |-> pslverr == (paddr > 8'h1C || paddr[1:0] != 2'b00);
    endproperty
    a_slverr: assert property (p_slverr) else $error("bad error flag");
endmodule
bind rstsup_top rstsup_top_monitor #(.PREC_HOLD(PREC_HOLD)) rstsup_top_monitor_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .supply_ramping,
    .external_reset_n, .system_reset_n, .digital_trip_code, .monitor_enable);
`default_nettype wire

// >>> verification/rstsup_core_model.sv
// Core model: counts system resets released to processor and peripherals
`timescale 1ns/1ps
`default_nettype none
module rstsup_core_model (
    input wire logic pclk, // Clock
    input wire logic presetn, // Power-on reset
    input wire logic system_reset_n, // System reset
    output logic [7:0] reset_count // Releases seen
);
    logic held;
    // Counted on release, so a long hold counts once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held <= 1'b0;
            reset_count <= 8'h00;
        end else begin
            held <= !system_reset_n;
            if (held && system_reset_n) begin
                reset_count <= reset_count + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verification/system_reset_supervisor_tb_top.sv
// Testbench: APB sequences and reset sources for the reset supervisor
`timescale 1ns/1ps
`default_nettype none
module system_reset_supervisor_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr, reset_count;
    logic [31:0] pwdata, prdata, q;
    logic digital_supply_low, analog_supply_low, analog_supply_high, supply_ramping;
    logic digital_core_regulator_low, analog_core_regulator_low, external_reset_n;
    logic system_reset_n, monitor_enable, precise_monitor_enable, analog_regulator_enable;
    logic lv_irq, wakeup;
    logic [3:0] digital_trip_code, analog_trip_code;
    int n_errors = 0;
    int checked = 0;
    int n;
    rstsup_top #(.PREC_HOLD(8)) rstsup_top_inst (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .digital_supply_low, .analog_supply_low,
        .analog_supply_high, .digital_core_regulator_low, .analog_core_regulator_low,
        .supply_ramping, .external_reset_n, .system_reset_n, .digital_trip_code,
        .analog_trip_code, .monitor_enable, .precise_monitor_enable,
        .analog_regulator_enable, .lv_irq, .wakeup);
    rstsup_core_model rstsup_core_model_inst (.pclk, .presetn, .system_reset_n, .reset_count);
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        checked++;
        if (g !== x) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // No local limit: only the watchdog process ends a stuck wait
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_rst(input logic lv, input int mx);
        int k;
        k = 0;
        while (system_reset_n !== lv && k < mx) begin
            k++;
            @(posedge pclk);
        end
        chk("system_reset_n", lv, 32'(system_reset_n));
    endtask
    task automatic status(input logic [31:0] x);
        apb(1'b0, rstsup_pkg::OFF_STATUS, 32'h0000_0000);
        chk("status", x, q);
    endtask
    task automatic por();
        @(posedge pclk);
        presetn <= 1'b0;
        supply_ramping <= 1'b1;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("ramp hold", 32'h0, 32'(system_reset_n));
        supply_ramping <= 1'b0;
        wait_rst(1'b1, 60);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Whole sequence needs a few hundred cycles; 20000 cycles is a hang
    initial begin
        #500_000;
        n_errors++;
        results();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {digital_supply_low, analog_supply_low, analog_supply_high} = '0;
        {digital_core_regulator_low, analog_core_regulator_low, supply_ramping} = '0;
        presetn = 1'b0;
        external_reset_n = 1'b1;
        por();
        apb(1'b0, rstsup_pkg::OFF_CTRL, 32'h0000_0000);
        chk("ctrl", rstsup_pkg::CTRL_RESET, q);
        chk("mon on", 32'h1, 32'(monitor_enable));
        chk("prec on", 32'h1, 32'(precise_monitor_enable));
        status(32'h0000_0000);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk("slverr", 32'h1, 32'(e));
        $display("test power-on done");
        apb(1'b1, rstsup_pkg::OFF_LVCFG, 32'h0000_0405);
        @(posedge pclk);
        chk("trip", 32'h5, 32'(digital_trip_code));
        apb(1'b1, rstsup_pkg::OFF_BUZZ, 32'h0000_0040);
        apb(1'b1, rstsup_pkg::OFF_MODE, 32'(rstsup_pkg::MODE_SLEEP));
        digital_supply_low <= 1'b1;
        for (n = 0; n < 1000 && wakeup !== 1'b1; n++) @(posedge pclk);
        chk("irq before wake", 32'h0, 32'(lv_irq));
        for (n = 0; n < 30 && lv_irq !== 1'b1; n++) @(posedge pclk);
        chk("irq after wake", 32'h1, 32'(lv_irq));
        digital_supply_low <= 1'b0;
        chk("irq no reset", 32'h1, 32'(system_reset_n));
        // The buzz window is nearly over; monitors must be live for the next pulse
        apb(1'b1, rstsup_pkg::OFF_MODE, 32'(rstsup_pkg::MODE_ACTIVE));
        apb(1'b1, rstsup_pkg::OFF_LVCFG, 32'h0000_0505);
        digital_supply_low <= 1'b1;
        repeat (4) @(posedge pclk);
        digital_supply_low <= 1'b0;
        wait_rst(1'b0, 10);
        wait_rst(1'b1, 60);
        chk("trip cleared", 32'(rstsup_pkg::TRIP_RESET), 32'(digital_trip_code));
        $display("test low-voltage done");
        apb(1'b1, rstsup_pkg::OFF_MODE, 32'(rstsup_pkg::MODE_HIBERNATE));
        @(posedge pclk);
        chk("prec off", 32'h0, 32'(precise_monitor_enable));
        external_reset_n <= 1'b0;
        wait_rst(1'b0, 10);
        repeat (20) @(posedge pclk);
        chk("pin hold", 32'h0, 32'(system_reset_n));
        external_reset_n <= 1'b1;
        wait_rst(1'b1, 60);
        apb(1'b0, rstsup_pkg::OFF_MODE, 32'h0000_0000);
        chk("mode", 32'(rstsup_pkg::MODE_ACTIVE), q);
        $display("test external done");
        apb(1'b1, rstsup_pkg::OFF_CTRL, 32'h0000_0003);
        apb(1'b1, rstsup_pkg::OFF_SWRST, 32'h0000_0001);
        repeat (10) @(posedge pclk);
        chk("sw blocked", 32'h1, 32'(system_reset_n));
        apb(1'b1, rstsup_pkg::OFF_CTRL, 32'h0000_0002);
        apb(1'b1, rstsup_pkg::OFF_SWRST, 32'h0000_0001);
        wait_rst(1'b0, 10);
        wait_rst(1'b1, 60);
        digital_core_regulator_low <= 1'b1;
        repeat (3) @(posedge pclk);
        digital_core_regulator_low <= 1'b0;
        wait_rst(1'b0, 10);
        wait_rst(1'b1, 60);
        $display("test software and precise done");
        apb(1'b1, rstsup_pkg::OFF_WDCTRL, 32'h0000_0041);
        apb(1'b1, rstsup_pkg::OFF_WDCTRL, 32'h0000_0040);
        apb(1'b0, rstsup_pkg::OFF_WDCTRL, 32'h0000_0000);
        chk("wd sticky", 32'h0000_0041, q);
        repeat (4) begin
            repeat (20) @(posedge pclk);
            apb(1'b1, rstsup_pkg::OFF_WDKICK, 32'h0000_0000);
        end
        chk("wd kicked", 32'h1, 32'(system_reset_n));
        wait_rst(1'b0, 300);
        wait_rst(1'b1, 60);
        status(32'h0000_009F);
        chk("core resets", 32'h6, 32'(reset_count));
        $display("test watchdog done");
        por();
        status(32'h0000_0000);
        apb(1'b0, rstsup_pkg::OFF_WDCTRL, 32'h0000_0000);
        chk("wd off", 32'h0, q & 32'h0000_0001);
        $display("test power-on clear done");
        results();
    end
endmodule
`default_nettype wire
